// ### rtl/vdp_cfg.svh
// Constants for the video DAC pixel port and host port
`ifndef VDP_CFG_SVH
`define VDP_CFG_SVH
`define VDP_PIXELS_PER_LOAD 8
`define VDP_CHAN_BITS 8
`define VDP_CHANNELS 3
`define VDP_SEL_PTR_LO 2'h0
`define VDP_SEL_PTR_HI 2'h1
`define VDP_SEL_REG 2'h2
`define VDP_SEL_RSVD 2'h3
`define VDP_RW_WRITE 1'h0
`define VDP_RW_READ 1'h1
`define VDP_ADDR_CMD_ONE 11'h400
`define VDP_ADDR_CMD_TWO 11'h411
`define VDP_CMD_RESET 8'h00
`define VDP_PTR_RESET 16'h0000
`define VDP_READ_ZERO 8'h00
`define VDP_CODE_BLANK 8'h00
`define VDP_BIT_BLANK_INV 0
`define VDP_BIT_SYNC_INV 1
`define VDP_BIT_SYNC_BLUE 2
`define VDP_BIT_SYNC_GREEN 3
`define VDP_BIT_SYNC_RED 4
`define VDP_BIT_PLL 0
`define VDP_BIT_SYNCOUT 3
`define VDP_BIT_SENSE 5
`define VDP_PERIOD_BITS 12
`endif

// ### rtl/vdp_pkg.sv
// Types shared by the video DAC pixel port and host port
`include "vdp_cfg.svh"
package vdp_pkg;
  typedef struct packed {
    logic [`VDP_PIXELS_PER_LOAD*`VDP_CHAN_BITS-1:0] red;
    logic [`VDP_PIXELS_PER_LOAD*`VDP_CHAN_BITS-1:0] green;
    logic [`VDP_PIXELS_PER_LOAD*`VDP_CHAN_BITS-1:0] blue;
  } vdp_color_word_t;
  typedef struct packed {
    logic hsync_n;
    logic vsync_n;
    logic composite_sync_n;
    logic blank_n;
  } vdp_ctrl_t;
  typedef struct packed {
    logic ce_n;
    logic rw;
    logic port_select_hi;
    logic port_select_lo;
    logic [7:0] data;
  } vdp_host_pins_t;
  typedef struct packed {
    logic [`VDP_CHAN_BITS-1:0] code;
    logic blank;
    logic sync;
  } vdp_chan_out_t;
endpackage

// ### rtl/vdp_pll_mult.sv
// Pixel-rate multiplier: eight pixel steps per load period, load clock out
`include "vdp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module vdp_pll_mult #(
  parameter int MULT = `VDP_PIXELS_PER_LOAD,
  parameter int PW = `VDP_PERIOD_BITS
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic load_rise,
  input wire logic pll_release_bit,
  output logic pixel_step,
  output logic [$clog2(MULT)-1:0] pixel_index,
  output logic pixel_load_clock_out,
  output logic locked
);
  localparam int IW = $clog2(MULT);
  logic [PW-1:0] cnt;
  logic [PW-1:0] period;
  logic [PW-1:0] acc;
  logic seen;
  // Fractional accumulator spreads MULT steps over one measured load period
  wire [PW:0] acc_sum = {1'b0, acc} + (PW+1)'(MULT);
  wire step_hit = locked && (acc_sum >= {1'b0, period});
  wire [PW-1:0] next_acc = step_hit ? PW'(acc_sum - {1'b0, period}) : acc_sum[PW-1:0];
  wire idx_last = (pixel_index == IW'(MULT-1));
  wire idx_half = (pixel_index == IW'(MULT/2-1));
  assign pixel_step = step_hit;

  // Divider held while the release bit is low; first pixel after release is A
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      period <= '0;
      acc <= '0;
      seen <= 1'b0;
      locked <= 1'b0;
      pixel_index <= '0;
      pixel_load_clock_out <= 1'b0;
    end else if (!pll_release_bit) begin
      cnt <= '0;
      period <= '0;
      acc <= '0;
      seen <= 1'b0;
      locked <= 1'b0;
      pixel_index <= '0;
      pixel_load_clock_out <= 1'b0;
    end else begin
      cnt <= load_rise ? '0 : cnt + 1'b1;
      if (load_rise) begin
        period <= cnt + 1'b1;
        seen <= 1'b1;
        locked <= seen; // First interval after release is partial
      end
      acc <= locked ? next_acc : '0;
      if (step_hit) begin
        pixel_index <= idx_last ? '0 : pixel_index + 1'b1;
        if (idx_last || idx_half) begin
          pixel_load_clock_out <= ~pixel_load_clock_out;
        end
      end
    end
  end

  // Helper: steps since the last load clock out toggle; a step in the toggle cycle opens the new count
  logic [IW:0] steps_since;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      steps_since <= '0;
    end else if (!pll_release_bit) begin
      steps_since <= '0;
    end else if ($changed(pixel_load_clock_out)) begin
      steps_since <= step_hit ? (IW+1)'(1) : '0;
    end else if (step_hit) begin
      steps_since <= steps_since + 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_pll_held_reset: assert property (!pll_release_bit |=> !locked && pixel_index == '0 && !pixel_load_clock_out)
    else $error("divider not held while release bit low");
  a_pixel_load_clock_out_eighth: assert property (pll_release_bit && $changed(pixel_load_clock_out) |-> steps_since == (IW+1)'(MULT/2))
    else $error("load clock out toggled off the eighth-rate boundary");
endmodule // vdp_pll_mult
`default_nettype wire

// ### rtl/vdp_host_port.sv
// Host port: pointer, two command registers, read-back on the 8-bit bus
`include "vdp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module vdp_host_port (
  input wire logic core_clk,
  input wire logic resetn,
  input wire vdp_pkg::vdp_host_pins_t host_pins_in,
  input wire logic monitor_absent,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  output logic [7:0] command_control_one,
  output logic [7:0] command_control_two,
  output logic [15:0] register_pointer
);
  vdp_pkg::vdp_host_pins_t pin_s1;
  vdp_pkg::vdp_host_pins_t pin_s2;
  vdp_pkg::vdp_host_pins_t pin_s3;
  // Pins are asynchronous; two flops, then a third stage for the enable edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1 <= '{ce_n: 1'b1, default: '0};
      pin_s2 <= '{ce_n: 1'b1, default: '0};
      pin_s3 <= '{ce_n: 1'b1, default: '0};
    end else begin
      pin_s1 <= host_pins_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Write commits at the end of the enable pulse using the last low sample
  wire access_end = pin_s2.ce_n && !pin_s3.ce_n;
  wire wr_take = access_end && (pin_s3.rw == `VDP_RW_WRITE);
  wire [1:0] wr_sel = {pin_s3.port_select_hi, pin_s3.port_select_lo};
  wire [1:0] rd_sel = {pin_s2.port_select_hi, pin_s2.port_select_lo};
  wire hit_one = (register_pointer[10:0] == `VDP_ADDR_CMD_ONE);
  wire hit_two = (register_pointer[10:0] == `VDP_ADDR_CMD_TWO);
  wire [7:0] two_view = {command_control_two[7:`VDP_BIT_SENSE+1], monitor_absent,
                         command_control_two[`VDP_BIT_SENSE-1:0]};
  wire [7:0] reg_view = hit_one ? command_control_one : (hit_two ? two_view : `VDP_READ_ZERO);
  wire [7:0] rd_val = (rd_sel == `VDP_SEL_PTR_LO) ? register_pointer[7:0] :
                      (rd_sel == `VDP_SEL_PTR_HI) ? register_pointer[15:8] :
                      (rd_sel == `VDP_SEL_REG) ? reg_view : `VDP_READ_ZERO;

  // Register file; reserved select or pointer values fall through untouched
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      register_pointer <= `VDP_PTR_RESET;
      command_control_one <= `VDP_CMD_RESET;
      command_control_two <= `VDP_CMD_RESET;
    end else if (wr_take) begin
      if (wr_sel == `VDP_SEL_PTR_LO) register_pointer[7:0] <= pin_s3.data;
      if (wr_sel == `VDP_SEL_PTR_HI) register_pointer[15:8] <= pin_s3.data;
      if (wr_sel == `VDP_SEL_REG && hit_one) command_control_one <= pin_s3.data;
      if (wr_sel == `VDP_SEL_REG && hit_two) command_control_two <= pin_s3.data;
    end
  end

  // Read data registered; bus driven only while enabled for a read
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      host_data_out <= `VDP_READ_ZERO;
      host_data_oe <= 1'b0;
    end else begin
      host_data_out <= rd_val;
      host_data_oe <= !pin_s2.ce_n && (pin_s2.rw == `VDP_RW_READ);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_cmd_one_write: assert property (wr_take && wr_sel == `VDP_SEL_REG && hit_one |=> command_control_one == $past(pin_s3.data))
    else $error("command one write lost");
  a_reserved_no_effect: assert property (wr_take && wr_sel == `VDP_SEL_RSVD |=> $stable(register_pointer) && $stable(command_control_one) && $stable(command_control_two))
    else $error("reserved select changed a register");
  a_reserved_read_zero: assert property (!pin_s2.ce_n && rd_sel == `VDP_SEL_REG && !hit_one && !hit_two |=> host_data_out == `VDP_READ_ZERO)
    else $error("reserved location read nonzero");
  a_ptr_lo_write: assert property (wr_take && wr_sel == `VDP_SEL_PTR_LO |=> register_pointer[7:0] == $past(pin_s3.data) && $stable(register_pointer[15:8]))
    else $error("pointer low write wrong");
endmodule // vdp_host_port
`default_nettype wire

// ### rtl/vdp_pixel_port.sv
// Video DAC digital front end: pixel capture, 8:1 mux, sync/blank, sense
`include "vdp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module vdp_pixel_port (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic pixel_load_clock_in,
  input wire vdp_pkg::vdp_color_word_t pixel_color_in,
  input wire vdp_pkg::vdp_ctrl_t pixel_ctrl_in,
  input wire vdp_pkg::vdp_host_pins_t host_pins_in,
  input wire logic [`VDP_CHANNELS-1:0] comparator_over,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  output logic pixel_load_clock_out,
  output logic pixel_strobe,
  output vdp_pkg::vdp_ctrl_t pixel_ctrl_out,
  output vdp_pkg::vdp_chan_out_t red_current_out,
  output vdp_pkg::vdp_chan_out_t green_current_out,
  output vdp_pkg::vdp_chan_out_t blue_current_out,
  output vdp_pkg::vdp_chan_out_t red_inverted_out,
  output vdp_pkg::vdp_chan_out_t green_inverted_out,
  output vdp_pkg::vdp_chan_out_t blue_inverted_out,
  output logic sense_out
);
  localparam int NPIX = `VDP_PIXELS_PER_LOAD;
  localparam int CB = `VDP_CHAN_BITS;
  localparam int NCH = `VDP_CHANNELS;
  localparam int IW = $clog2(NPIX);

  // Load clock sampler: two flops, third for edge finding
  logic load_s1;
  logic load_s2;
  logic load_s3;
  vdp_pkg::vdp_color_word_t color_s1;
  vdp_pkg::vdp_color_word_t color_s2;
  vdp_pkg::vdp_ctrl_t ctrl_s1;
  vdp_pkg::vdp_ctrl_t ctrl_s2;
  logic [NCH-1:0] comp_s1;
  logic [NCH-1:0] comp_s2;

  // Every pin passes two flops; data and clock see equal delay
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      load_s1 <= 1'b0;
      load_s2 <= 1'b0;
      load_s3 <= 1'b0;
      color_s1 <= '0;
      color_s2 <= '0;
      ctrl_s1 <= '1;
      ctrl_s2 <= '1;
      comp_s1 <= '0;
      comp_s2 <= '0;
    end else begin
      load_s1 <= pixel_load_clock_in;
      load_s2 <= load_s1;
      load_s3 <= load_s2;
      color_s1 <= pixel_color_in;
      color_s2 <= color_s1;
      ctrl_s1 <= pixel_ctrl_in;
      ctrl_s2 <= ctrl_s1;
      comp_s1 <= comparator_over;
      comp_s2 <= comp_s1;
    end
  end

  wire load_rise = load_s2 && !load_s3;

  logic monitor_absent;
  logic [7:0] command_control_one;
  logic [7:0] command_control_two;
  logic [15:0] register_pointer;
  logic pixel_step;
  logic [IW-1:0] pixel_index;
  logic pll_locked;

  // Host side registers
  vdp_host_port u_host (
    .core_clk(core_clk),
    .resetn(resetn),
    .host_pins_in(host_pins_in),
    .monitor_absent(monitor_absent),
    .host_data_out(host_data_out),
    .host_data_oe(host_data_oe),
    .command_control_one(command_control_one),
    .command_control_two(command_control_two),
    .register_pointer(register_pointer)
  );

  // Pixel-rate generator, released by the command two control bit
  vdp_pll_mult #(
    .MULT(NPIX),
    .PW(`VDP_PERIOD_BITS)
  ) u_pll (
    .core_clk(core_clk),
    .resetn(resetn),
    .load_rise(load_rise),
    .pll_release_bit(command_control_two[`VDP_BIT_PLL]),
    .pixel_step(pixel_step),
    .pixel_index(pixel_index),
    .pixel_load_clock_out(pixel_load_clock_out),
    .locked(pll_locked)
  );

  // Capture word and controls on each load edge; the mux drains it later
  vdp_pkg::vdp_color_word_t pending_word;
  vdp_pkg::vdp_ctrl_t pending_ctrl;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pending_word <= '0;
      pending_ctrl <= '1;
    end else if (load_rise) begin
      pending_word <= color_s2;
      pending_ctrl <= ctrl_s2;
    end
  end

  // Word, controls and mode bits are swapped in only at pixel A
  vdp_pkg::vdp_color_word_t active_word;
  vdp_pkg::vdp_ctrl_t active_ctrl;
  logic [7:0] cmd_one_act;
  wire at_first = (pixel_index == '0);
  wire take_word = pixel_step && at_first;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      active_word <= '0;
      active_ctrl <= '1;
      cmd_one_act <= `VDP_CMD_RESET;
    end else if (take_word) begin
      active_word <= pending_word;
      active_ctrl <= pending_ctrl;
      cmd_one_act <= command_control_one;
    end
  end

  wire [$bits(vdp_pkg::vdp_color_word_t)-1:0] shown_bits = at_first ? pending_word : active_word;
  wire vdp_pkg::vdp_color_word_t shown_word = shown_bits;
  wire vdp_pkg::vdp_ctrl_t cur_ctrl = at_first ? pending_ctrl : active_ctrl;
  wire [7:0] cur_cmd_one = at_first ? command_control_one : cmd_one_act;
  wire blank_now = !cur_ctrl.blank_n;
  wire sync_now = !cur_ctrl.composite_sync_n;

  // Channel words: 0 red, 1 green, 2 blue
  wire [NCH-1:0][NPIX*CB-1:0] chan_word = {shown_word.blue, shown_word.green, shown_word.red};
  vdp_pkg::vdp_chan_out_t chan_q [NCH];
  vdp_pkg::vdp_chan_out_t inv_q [NCH];

  // One output stage per channel; code held between pixel steps
  for (genvar c = 0; c < NCH; c++) begin : g_chan
    localparam int EN_BIT = `VDP_BIT_SYNC_RED - c;
    wire [CB-1:0] code_sel = chan_word[c][pixel_index*CB +: CB];
    wire [CB-1:0] code_lvl = blank_now ? `VDP_CODE_BLANK : code_sel;
    wire sync_lvl = sync_now && cur_cmd_one[EN_BIT];
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        chan_q[c] <= '0;
        inv_q[c] <= '0;
      end else if (pixel_step) begin
        chan_q[c].code <= code_lvl;
        chan_q[c].blank <= blank_now;
        chan_q[c].sync <= sync_lvl;
        inv_q[c].code <= ~code_lvl;
        inv_q[c].blank <= blank_now && cur_cmd_one[`VDP_BIT_BLANK_INV];
        inv_q[c].sync <= sync_lvl && cur_cmd_one[`VDP_BIT_SYNC_INV];
      end
    end
  end

  assign red_current_out = chan_q[0];
  assign green_current_out = chan_q[1];
  assign blue_current_out = chan_q[2];
  assign red_inverted_out = inv_q[0];
  assign green_inverted_out = inv_q[1];
  assign blue_inverted_out = inv_q[2];

  // Controls follow the pixel they belong to; strobe marks each new pixel
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pixel_ctrl_out <= '1;
      pixel_strobe <= 1'b0;
    end else begin
      pixel_strobe <= pixel_step;
      if (pixel_step) begin
        pixel_ctrl_out <= cur_ctrl;
      end
    end
  end

  // Sense pin: comparator result, or pipelined composite sync when chosen
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      monitor_absent <= 1'b0;
      sense_out <= 1'b0;
    end else begin
      monitor_absent <= |comp_s2;
      sense_out <= command_control_two[`VDP_BIT_SYNCOUT] ? pixel_ctrl_out.composite_sync_n : monitor_absent;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Step through pixel A of a fresh word, then the next pixel
  sequence s_step_a;
    pixel_step && at_first && !blank_now;
  endsequence
  sequence s_step_b;
    pixel_step && pixel_index == IW'(1) && !blank_now;
  endsequence

  a_color_capture: assert property (load_rise |=> pending_word == $past(color_s2))
    else $error("color word not captured on load edge");
  a_ctrl_capture: assert property (load_rise |=> pending_ctrl == $past(ctrl_s2))
    else $error("sync or blank not captured with color");
  a_mux_first_pixel: assert property (s_step_a |=> red_current_out.code == $past(pending_word.red[CB-1:0]))
    else $error("pixel A not shown first");
  a_mux_second_pixel: assert property (s_step_b |=> blue_current_out.code == $past(active_word.blue[2*CB-1:CB]))
    else $error("pixel B not shown second");
  a_blank_forces_level: assert property (pixel_step && blank_now |=> red_current_out.blank && red_current_out.code == `VDP_CODE_BLANK)
    else $error("blank did not force blank level");
  a_sync_enable_gate: assert property (pixel_step && !cur_cmd_one[`VDP_BIT_SYNC_GREEN] |=> !green_current_out.sync)
    else $error("sync shown on disabled channel");
  a_inverted_gate: assert property (pixel_step && !cur_cmd_one[`VDP_BIT_BLANK_INV] |=> !red_inverted_out.blank)
    else $error("blank on inverted output while disabled");
  a_monitor_flag: assert property ((|comp_s2) |=> monitor_absent)
    else $error("monitor-absent flag missed comparator");
  a_mode_at_boundary: assert property (pixel_step && !at_first |=> $stable(cmd_one_act))
    else $error("mode bits changed mid word");
endmodule // vdp_pixel_port
`default_nettype wire

// ### tb/vdp_fb_model.sv
// Frame-buffer gate array model: load clock, pixel words and pixel controls
`timescale 1ns/1ps
`default_nettype none
module vdp_fb_model (
  input wire logic blank_n,
  input wire logic composite_sync_n_n,
  output logic pixel_load_clock_in,
  output vdp_pkg::vdp_color_word_t pixel_color_in,
  output vdp_pkg::vdp_ctrl_t pixel_ctrl_in
);
  logic [3:0] word_no;
  logic [1:0] ctrl_q;
  // The gate array clock runs free; 80 ns period, unrelated to core_clk
  initial begin
    pixel_load_clock_in = 1'b0;
    word_no = 4'h0;
    ctrl_q = 2'h3;
  end
  always #40 pixel_load_clock_in = ~pixel_load_clock_in;
  // New word on the falling edge so it is settled across the rising edge
  always @(negedge pixel_load_clock_in) begin
    word_no <= word_no + 4'h1;
    ctrl_q <= {composite_sync_n_n, blank_n};
  end
  // Pixel k: red carries word and index, green its inverse, blue scrambled
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      pixel_color_in.red[8*k +: 8] = {word_no, 4'(k)};
      pixel_color_in.green[8*k +: 8] = ~{word_no, 4'(k)};
      pixel_color_in.blue[8*k +: 8] = {word_no, 4'(k)} ^ 8'h5A;
    end
    pixel_ctrl_in = {2'h3, ctrl_q};
  end
endmodule // vdp_fb_model
`default_nettype wire

// ### tb/tb_video_dac_pixel_and_mpu_port.sv
// Self-checking bench for the pixel port and the host register port
`include "vdp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_video_dac_pixel_and_mpu_port;
  logic core_clk, resetn, load_in, host_oe, load_out, strobe, sense, blank_n, composite_sync_n_n, ce_n, rw;
  logic [7:0] host_dout, tb_data, rd_val;
  logic [2:0] cmp_over;
  logic [1:0] sel;
  logic [15:0] mode;
  vdp_pkg::vdp_color_word_t color;
  vdp_pkg::vdp_ctrl_t ctrl_in, ctrl_out;
  vdp_pkg::vdp_host_pins_t pins;
  vdp_pkg::vdp_chan_out_t red, green, blue, red_inv, green_inv, blue_inv;
  int n_errors, check_count, cycles, steps;
  // Rows: command one, blank_n, composite_sync_n_n, then expected {r blank, ri blank, r/g/b sync, ri sync}
  localparam logic [15:0] MODES [0:7] = '{16'h1C60, 16'h1F70, 16'h1C8E, 16'h1088,
                                          16'h0884, 16'h0482, 16'h0080, 16'h1289};
  // Resolved data wire: the device wins while its enable is high
  assign pins = {ce_n, rw, sel, host_oe ? host_dout : tb_data};
  vdp_fb_model fb (.blank_n(blank_n), .composite_sync_n_n(composite_sync_n_n), .pixel_load_clock_in(load_in),
    .pixel_color_in(color), .pixel_ctrl_in(ctrl_in));
  vdp_pixel_port uut (.core_clk(core_clk), .resetn(resetn), .pixel_load_clock_in(load_in),
    .pixel_color_in(color), .pixel_ctrl_in(ctrl_in), .host_pins_in(pins), .comparator_over(cmp_over),
    .host_data_out(host_dout), .host_data_oe(host_oe), .pixel_load_clock_out(load_out),
    .pixel_strobe(strobe), .pixel_ctrl_out(ctrl_out), .red_current_out(red), .green_current_out(green),
    .blue_current_out(blue), .red_inverted_out(red_inv), .green_inverted_out(green_inv),
    .blue_inverted_out(blue_inv), .sense_out(sense));
  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;
  task automatic final_report();
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // A hung handshake must not stall the run forever
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors = n_errors + 1;
      final_report();
    end
  end
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // One host access; strobes held well past the three-cycle synchroniser
  task automatic host_cycle(input logic [1:0] s, input logic r, input logic [7:0] d);
    @(negedge core_clk);
    sel = s;
    rw = r;
    tb_data = r ? ~tb_data : d;
    ce_n = 1'b0;
    repeat (6) @(negedge core_clk);
    for (int i = 0; i < 10 && r && host_oe !== 1'b1; i++) @(negedge core_clk);
    rd_val = host_dout;
    ce_n = 1'b1;
    repeat (6) @(negedge core_clk);
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    host_cycle(s, 1'b0, d);
  endtask
  task automatic rd(input logic [1:0] s, input logic [7:0] exp, input string what);
    host_cycle(s, 1'b1, 8'h00);
    chk8(what, exp, rd_val);
  endtask
  task automatic set_ptr(input logic [15:0] a);
    wr(`VDP_SEL_PTR_LO, a[7:0]);
    wr(`VDP_SEL_PTR_HI, a[15:8]);
  endtask
  // Waits for the next pixel step, sampled after the edge settles
  task automatic next_pixel();
    int i;
    i = 0;
    do begin
      @(posedge core_clk);
      #1;
      i++;
    end while (strobe !== 1'b1 && i < 100);
    chk8("pixel_strobe", 8'h01, {7'h00, strobe});
  endtask
  // Eight steps A..H of one word; the word number is the only unknown
  task automatic check_seq();
    logic [7:0] first;
    next_pixel();
    first = red.code;
    for (int k = 0; k < 8; k++) begin
      if (k > 0) next_pixel();
      chk8("red code", {first[7:4], 4'(k)}, red.code);
      chk8("green code", ~{first[7:4], 4'(k)}, green.code);
      chk8("blue code", {first[7:4], 4'(k)} ^ 8'h5A, blue.code);
      chk8("red inverted code", ~{first[7:4], 4'(k)}, red_inv.code);
      chk8("green inverted code", {first[7:4], 4'(k)}, green_inv.code);
      chk8("blue inverted code", ~({first[7:4], 4'(k)} ^ 8'h5A), blue_inv.code);
    end
  endtask
  initial begin
    {resetn, ce_n, rw, sel, tb_data, blank_n, composite_sync_n_n, cmp_over} = {1'b0, 1'b1, 1'b1, 2'h0, 8'h00, 2'h3, 3'h0};
    {n_errors, check_count, cycles} = {32'd0, 32'd0, 32'd0};
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    rd(`VDP_SEL_PTR_LO, 8'h00, "pointer low");
    set_ptr(16'hF411);
    rd(`VDP_SEL_PTR_LO, 8'h11, "pointer low");
    rd(`VDP_SEL_PTR_HI, 8'hF4, "pointer high");
    rd(`VDP_SEL_REG, 8'h00, "command two");
    set_ptr(16'h0400);
    wr(`VDP_SEL_REG, 8'h1C);
    rd(`VDP_SEL_REG, 8'h1C, "command one");
    set_ptr(16'h0412);
    wr(`VDP_SEL_REG, 8'hFF);
    rd(`VDP_SEL_REG, 8'h00, "reserved register");
    wr(`VDP_SEL_RSVD, 8'h55);
    rd(`VDP_SEL_RSVD, 8'h00, "reserved select");
    rd(`VDP_SEL_PTR_LO, 8'h12, "pointer low");
    set_ptr(16'h0411);
    // Hold the divider, check silence, then release twice to see realignment
    for (int p = 0; p < 2; p++) begin
      wr(`VDP_SEL_REG, 8'h00);
      steps = 0;
      repeat (40) @(negedge core_clk) steps += strobe;
      chk8("steps while held", 8'h00, 8'(steps));
      chk8("load out while held", 8'h00, {7'h00, load_out});
      wr(`VDP_SEL_REG, 8'h01);
      check_seq();
    end
    // Steps in one load-out period, half-open window
    steps = 0;
    for (int i = 0, e = 0, pv = 1; i < 200 && e < 2; i++) begin
      @(posedge core_clk);
      #1;
      if (e == 1 && strobe === 1'b1) steps++;
      if (load_out === 1'b1 && pv == 0) e++;
      pv = load_out;
    end
    chk8("steps per load out", 8'h08, 8'(steps));
    rd(`VDP_SEL_REG, 8'h01, "command two");
    foreach (MODES[m]) begin
      mode = MODES[m];
      set_ptr(16'h0400);
      wr(`VDP_SEL_REG, mode[15:8]);
      @(negedge core_clk);
      {blank_n, composite_sync_n_n} = mode[7:6];
      repeat (50) @(negedge core_clk);
      next_pixel();
      chk8("ctrl blank", {7'h00, mode[7]}, {7'h00, ctrl_out.blank_n});
      chk8("red blank", {7'h00, mode[5]}, {7'h00, red.blank});
      if (!mode[7]) chk8("blanked code", 8'h00, red.code);
      chk8("inverted blank", {7'h00, mode[4]}, {7'h00, red_inv.blank});
      chk8("inverted blank gb", {6'h00, mode[4], mode[4]}, {6'h00, green_inv.blank, blue_inv.blank});
      chk8("ctrl out", {4'h0, 2'h3, mode[6], mode[7]}, {4'h0, ctrl_out});
      chk8("sync rgb", {5'h00, mode[3:1]}, {5'h00, red.sync, green.sync, blue.sync});
      chk8("inverted sync", {7'h00, mode[0]}, {7'h00, red_inv.sync});
      chk8("inverted sync gb", 8'h00, {6'h00, green_inv.sync, blue_inv.sync});
    end
    cmp_over = 3'b010;
    repeat (20) @(negedge core_clk);
    chk8("sense", 8'h01, {7'h00, sense});
    set_ptr(16'h0411);
    rd(`VDP_SEL_REG, 8'h21, "command two sense");
    wr(`VDP_SEL_REG, 8'h09);
    composite_sync_n_n = 1'b0;
    repeat (50) @(negedge core_clk);
    chk8("sense as sync", 8'h00, {7'h00, sense});
    final_report();
  end
endmodule // tb_video_dac_pixel_and_mpu_port
`default_nettype wire
